// >>> led_sink_map.svh
`ifndef LED_SINK_MAP_SVH
`define LED_SINK_MAP_SVH

// ****************************************
// Widths and values
// ****************************************
`define CHAN_COUNT 16
`define CHAN_LAST_BIT 4'hF
`define SHIFT_RESET_VALUE 16'h0000
`define LATCH_RESET_VALUE 16'h0000
// Arbitrary stand-in for the undisclosed test pattern
`define TEST_PATTERN 16'hA5A5
`define FIFO_DEPTH 8

// ****************************************
// Link timing, in clk_sys_i cycles
// ****************************************
// Each link level is held long enough for the three-stage sampler
`define LINK_HALF_LAST 3'h3

`endif

// >>> led_sink_pkg.sv
package led_sink_pkg;
	`include "led_sink_map.svh"

	typedef logic [`CHAN_COUNT-1:0] chan_word_t;

	typedef enum logic [2:0] {
		H_IDLE,
		H_LOW,
		H_HIGH,
		H_LAT_HI,
		H_LAT_LO
	} host_state_t;

	typedef struct packed {
		logic [2:0] clk_s;
		logic [2:0] dat_s;
		logic [2:0] lat_s;
		logic [2:0] blk_s;
		logic clk_f;
		logic dat_f;
		logic lat_f;
		logic blk_f;
		chan_word_t shift;
		chan_word_t latch;
		chan_word_t sink;
		logic sdo;
	} dev_state_t;

	typedef struct packed {
		host_state_t state;
		logic [2:0] tmr;
		logic [3:0] bit_cnt;
		chan_word_t shreg;
		logic sclk;
		logic sdat;
		logic lat;
		logic blank;
		logic loaded;
	} host_reg_t;
endpackage

// >>> led_sink_if.sv
`timescale 1ns/1ps
interface led_sink_if;
	logic serial_shift_clock;
	logic serial_data_in;
	logic latch_strobe;
	logic output_blanking;
	logic serial_data_out;

	modport device (
		input serial_shift_clock,
		input serial_data_in,
		input latch_strobe,
		input output_blanking,
		output serial_data_out
	);

	modport host (
		output serial_shift_clock,
		output serial_data_in,
		output latch_strobe,
		output output_blanking,
		input serial_data_out
	);
endinterface

// >>> led_sink_device.sv
`timescale 1ns/1ps
`include "led_sink_map.svh"
module led_sink_device
	import led_sink_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	led_sink_if.device link,
	output logic [`CHAN_COUNT-1:0] sink_output_n_o
);

	dev_state_t r_r;
	dev_state_t r_nxt;

	// ****************************************
	// Sampler filter
	// ****************************************
	// Level moves only once stages two and three agree
	function automatic logic filt(input logic [2:0] s, input logic f);
		filt = (s[1] == s[2]) ? s[1] : f;
	endfunction

	logic clk_rise;
	logic lat_rise;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		r_nxt = r_r;
		r_nxt.clk_s = {r_r.clk_s[1:0], link.serial_shift_clock};
		r_nxt.dat_s = {r_r.dat_s[1:0], link.serial_data_in};
		r_nxt.lat_s = {r_r.lat_s[1:0], link.latch_strobe};
		r_nxt.blk_s = {r_r.blk_s[1:0], link.output_blanking};
		r_nxt.clk_f = filt(r_r.clk_s, r_r.clk_f);
		r_nxt.dat_f = filt(r_r.dat_s, r_r.dat_f);
		r_nxt.lat_f = filt(r_r.lat_s, r_r.lat_f);
		r_nxt.blk_f = filt(r_r.blk_s, r_r.blk_f);
		clk_rise = r_nxt.clk_f & ~r_r.clk_f;
		lat_rise = r_nxt.lat_f & ~r_r.lat_f;
		// Latch wins over a coincident shift; host keeps them apart
		if (lat_rise) begin
			r_nxt.latch = r_r.shift;
			r_nxt.shift = `TEST_PATTERN;
		end else if (clk_rise) begin
			r_nxt.shift = {r_r.shift[`CHAN_COUNT-2:0], r_r.dat_f};
		end
		if (clk_rise) begin
			r_nxt.sdo = r_nxt.shift[`CHAN_COUNT-1];
		end
		// Gated by the filtered blank level, not the raw pin
		r_nxt.sink = r_nxt.blk_f ? '0 : r_nxt.latch;
	end

	// ****************************************
	// Registers
	// ****************************************
	// Shift and latch reset values carry no meaning for the user
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			r_r <= '0;
			r_r.clk_s <= 3'h0;
			r_r.blk_s <= 3'h7;
			r_r.blk_f <= 1'b1;
			r_r.shift <= `SHIFT_RESET_VALUE;
			r_r.latch <= `LATCH_RESET_VALUE;
		end else begin
			r_r <= r_nxt;
		end
	end

	assign link.serial_data_out = r_r.sdo;
	assign sink_output_n_o = r_r.sink;
endmodule

// >>> led_sink_host.sv
`timescale 1ns/1ps
`include "led_sink_map.svh"
module led_sink_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	// ****************************************
	// Storage and pointers
	// ****************************************
	// Count kept beside the pointers so full and empty need no wrap bit
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [CW-1:0] cnt;
		logic ready;
		logic valid;
	} fifo_reg_t;

	fifo_reg_t f_r;
	fifo_reg_t f_nxt;

	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction

	logic push;
	logic pop;

	// ****************************************
	// Occupancy and flags
	// ****************************************
	always_comb begin
		f_nxt = f_r;
		push = in_valid_i & f_r.ready;
		pop = f_r.valid & out_ready_i;
		if (push) begin
			f_nxt.mem[f_r.wr] = in_data_i;
			f_nxt.wr = ptr_inc(f_r.wr);
		end
		if (pop) begin
			f_nxt.rd = ptr_inc(f_r.rd);
		end
		if (push && !pop) begin
			f_nxt.cnt = CW'(f_r.cnt + 1'b1);
		end else if (pop && !push) begin
			f_nxt.cnt = CW'(f_r.cnt - 1'b1);
		end
		// Flags registered so both handshakes leave from flops
		f_nxt.ready = (f_nxt.cnt != CW'(DEPTH));
		f_nxt.valid = (f_nxt.cnt != '0);
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			f_r <= '0;
			f_r.ready <= 1'b1;
		end else begin
			f_r <= f_nxt;
		end
	end

	// ****************************************
	// Handshake outputs
	// ****************************************
	assign in_ready_o = f_r.ready;
	assign out_valid_o = f_r.valid;
	assign out_data_o = f_r.mem[f_r.rd];
endmodule

module led_sink_host
	import led_sink_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic word_valid_i,
	input wire logic [`CHAN_COUNT-1:0] word_data_i,
	output logic word_ready_o,
	input wire logic blank_req_i,
	output logic loaded_o,
	led_sink_if.host link
);

	host_reg_t r_r;
	host_reg_t r_nxt;
	logic fifo_valid;
	chan_word_t fifo_data;
	logic fifo_pop;
	logic tmr_done;

	// ****************************************
	// Word queue
	// ****************************************
	// Lets the user post a burst while one frame at a time goes out
	led_sink_fifo #(
		.WIDTH(`CHAN_COUNT),
		.DEPTH(`FIFO_DEPTH)
	) u_fifo (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.in_valid_i(word_valid_i),
		.in_data_i(word_data_i),
		.in_ready_o(word_ready_o),
		.out_valid_o(fifo_valid),
		.out_data_o(fifo_data),
		.out_ready_i(fifo_pop)
	);

	// Words wait in the FIFO while a frame is on the link
	assign fifo_pop = (r_r.state == H_IDLE);

	// ****************************************
	// Frame sequencer
	// ****************************************
	always_comb begin
		r_nxt = r_r;
		tmr_done = (r_r.tmr == `LINK_HALF_LAST);
		r_nxt.tmr = tmr_done ? 3'h0 : 3'(r_r.tmr + 1'b1);
		unique case (r_r.state)
			H_IDLE: begin
				r_nxt.tmr = 3'h0;
				if (fifo_valid) begin
					// MSB first so it lands in bit 15 after sixteen shifts
					r_nxt.shreg = fifo_data;
					r_nxt.sdat = fifo_data[`CHAN_COUNT-1];
					r_nxt.bit_cnt = 4'h0;
					r_nxt.state = H_LOW;
				end
			end
			H_LOW: begin
				// Data moved with the last fall, so it is steady a full half either side
				if (tmr_done) begin
					r_nxt.sclk = 1'b1;
					r_nxt.state = H_HIGH;
				end
			end
			H_HIGH: begin
				if (tmr_done) begin
					r_nxt.sclk = 1'b0;
					if (r_r.bit_cnt == `CHAN_LAST_BIT) begin
						// Strobe rises with the last fall, never beside a rise
						r_nxt.lat = 1'b1;
						r_nxt.state = H_LAT_HI;
					end else begin
						// Next bit down, MSB first
						r_nxt.shreg = {r_r.shreg[`CHAN_COUNT-2:0], 1'b0};
						r_nxt.sdat = r_r.shreg[`CHAN_COUNT-2];
						r_nxt.bit_cnt = 4'(r_r.bit_cnt + 1'b1);
						r_nxt.state = H_LOW;
					end
				end
			end
			H_LAT_HI: begin
				if (tmr_done) begin
					r_nxt.lat = 1'b0;
					r_nxt.state = H_LAT_LO;
				end
			end
			H_LAT_LO: begin
				// Low half keeps the next frame's first rise clear of the strobe
				if (tmr_done) begin
					r_nxt.loaded = 1'b1;
					r_nxt.state = H_IDLE;
				end
			end
		endcase
		// Unused channels are the user's to zero in the word
		r_nxt.blank = ~r_nxt.loaded | blank_req_i;
	end

	// ****************************************
	// Registers
	// ****************************************
	// Blanking held from reset until a whole word is latched
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			r_r <= '0;
			r_r.state <= H_IDLE;
			r_r.blank <= 1'b1;
		end else begin
			r_r <= r_nxt;
		end
	end

	// ****************************************
	// Pins
	// ****************************************
	assign link.serial_shift_clock = r_r.sclk;
	assign link.serial_data_in = r_r.sdat;
	assign link.latch_strobe = r_r.lat;
	assign link.output_blanking = r_r.blank;
	assign loaded_o = r_r.loaded;
endmodule

// >>> led_sink_props.sv
`timescale 1ns/1ps
module led_sink_props
	import led_sink_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic serial_shift_clock,
	input wire logic serial_data_in,
	input wire logic latch_strobe,
	input wire logic output_blanking,
	input wire logic serial_data_out,
	input wire chan_word_t sink_output_n_o
);
	logic sclk_q;
	logic lat_q;
	logic first;
	logic seen_lat;
	logic [4:0] cnt;
	chan_word_t sh_w;
	chan_word_t lat_w;
	wire act = serial_shift_clock | latch_strobe;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	// ****
	// Shadow of the shift chain
	// ****
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			sclk_q <= 1'b0;
			lat_q <= 1'b0;
			first <= 1'b0;
			seen_lat <= 1'b0;
			cnt <= 5'h00;
			sh_w <= 16'h0000;
			lat_w <= 16'h0000;
		end else begin
			sclk_q <= serial_shift_clock;
			lat_q <= latch_strobe;
			if (serial_shift_clock && !sclk_q) begin
				sh_w <= {sh_w[14:0], serial_data_in};
				cnt <= cnt + 5'h01;
				if (cnt == 5'h00) first <= serial_data_in;
			end
			if (latch_strobe && !lat_q) begin
				lat_w <= sh_w;
				cnt <= 5'h00;
				seen_lat <= 1'b1;
			end
		end
	end
	property p_blank_off; output_blanking [*7] |-> sink_output_n_o == 16'h0000; endproperty
	a_blank_off: assert property (p_blank_off) else $error("sink on while blanked");
	property p_blank_fast; $rose(output_blanking) |-> ##[1:6] sink_output_n_o == 16'h0000; endproperty
	a_blank_fast: assert property (p_blank_fast) else $error("blanking too slow");
	property p_follow; (!output_blanking && !latch_strobe) [*7] |-> sink_output_n_o == lat_w; endproperty
	a_follow: assert property (p_follow) else $error("sink differs from latch");
	property p_sdo_when; $changed(serial_data_out) |-> $past(act, 2); endproperty
	a_sdo_when: assert property (p_sdo_when) else $error("serial out moved off an edge");
	property p_sdo_msb; $rose(latch_strobe) |-> ##2 serial_data_out == first; endproperty
	a_sdo_msb: assert property (p_sdo_msb) else $error("serial out not first bit");
	property p_frame; $rose(latch_strobe) |-> cnt == 5'h10; endproperty
	a_frame: assert property (p_frame) else $error("latch without 16 shifts");
	property p_sclk_len; $rose(serial_shift_clock) |-> serial_shift_clock [*4] ##1 !serial_shift_clock; endproperty
	a_sclk_len: assert property (p_sclk_len) else $error("shift clock high length");
	property p_rst_q; $fell(rst_i) |-> sink_output_n_o == 16'h0000 && !serial_data_out; endproperty
	a_rst_q: assert property (p_rst_q) else $error("outputs not quiet at reset");
	property p_rst_blank; $fell(rst_i) |-> output_blanking; endproperty
	a_rst_blank: assert property (p_rst_blank) else $error("blanking low after reset");
	property p_load_first; $fell(output_blanking) |-> seen_lat; endproperty
	a_load_first: assert property (p_load_first) else $error("blanking released before a latch");
	c_frame: cover property ($rose(latch_strobe));
	c_blank: cover property ($rose(output_blanking));
	c_unblank: cover property ($fell(output_blanking));
endmodule

// >>> test_led_sink_onoff_shift_latch.sv
`timescale 1ns/1ps
`include "led_sink_map.svh"
module test_led_sink_onoff_shift_latch;
	import led_sink_pkg::*;
	`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin bad_count++; \
		$display("CHECK FAILED %s exp %h got %h", n, e, a); end end
	typedef struct packed {chan_word_t word; chan_word_t sink;} row_t;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic word_valid_i = 1'b0;
	chan_word_t word_data_i = 16'h0000;
	logic blank_req_i = 1'b0;
	logic word_ready_o;
	logic loaded_o;
	chan_word_t sink_output_n_o;
	chan_word_t last;
	int bad_count = 0;
	int n_checks = 0;
	int cyc = 0;
	int n;
	row_t rows [5] = '{'{16'h0001, 16'h0001}, '{16'h8000, 16'h8000}, '{16'hFFFF, 16'hFFFF},
		'{16'h0000, 16'h0000}, '{16'h5A3C, 16'h5A3C}};
	led_sink_if led_sink_if_i ();
	led_sink_host led_sink_host_i (.clk_sys_i, .rst_i, .word_valid_i, .word_data_i, .word_ready_o,
		.blank_req_i, .loaded_o, .link(led_sink_if_i));
	led_sink_device led_sink_device_i (.clk_sys_i, .rst_i, .link(led_sink_if_i), .sink_output_n_o);
	led_sink_props led_sink_props_i (.clk_sys_i, .rst_i,
		.serial_shift_clock(led_sink_if_i.serial_shift_clock), .serial_data_in(led_sink_if_i.serial_data_in),
		.latch_strobe(led_sink_if_i.latch_strobe), .output_blanking(led_sink_if_i.output_blanking),
		.serial_data_out(led_sink_if_i.serial_data_out), .sink_output_n_o);
	initial begin
		forever #10 clk_sys_i = ~clk_sys_i;
	end
	task print_verdict;
		$display("TB: checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Ready is a flop, so its value at the falling edge is what the next rise sees
	task send(input chan_word_t w);
		logic r;
		begin
			word_data_i = w;
			word_valid_i = 1'b1;
			r = word_ready_o;
			@(negedge clk_sys_i);
			while (r !== 1'b1) begin
				r = word_ready_o;
				@(negedge clk_sys_i);
			end
			word_valid_i = 1'b0;
		end
	endtask
	task frame_done;
		wait (led_sink_if_i.latch_strobe === 1'b1);
		wait (led_sink_if_i.latch_strobe === 1'b0);
		repeat (12) @(negedge clk_sys_i);
	endtask
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			bad_count++;
			print_verdict;
		end
	end
	initial begin
		repeat (16) @(negedge clk_sys_i);
		rst_i = 1'b0;
		`CHK("sink_reset", 16'h0000, sink_output_n_o)
		`CHK("loaded_reset", 1'b0, loaded_o)
		for (int i = 0; i < 5; i++) begin
			send(rows[i].word);
			frame_done();
			`CHK("sink_row", rows[i].sink, sink_output_n_o)
		end
		`CHK("loaded_set", 1'b1, loaded_o)
		$display("TB: rows done");
		blank_req_i = 1'b1;
		repeat (8) @(negedge clk_sys_i);
		`CHK("sink_blanked", 16'h0000, sink_output_n_o)
		blank_req_i = 1'b0;
		repeat (8) @(negedge clk_sys_i);
		`CHK("sink_unblanked", 16'h5A3C, sink_output_n_o)
		$display("TB: blanking done");
		// Fill past depth while the link drains one frame at a time
		n = 0;
		word_valid_i = 1'b1;
		// New word only after the last was taken; stop offering once ready drops
		while (word_ready_o === 1'b1 && n < 12) begin
			word_data_i = word_data_i + 16'h1111;
			last = word_data_i;
			n++;
			@(negedge clk_sys_i);
		end
		word_valid_i = 1'b0;
		`CHK("ready_full", 1'b0, word_ready_o)
		`CHK("words_taken", `FIFO_DEPTH + 1, n)
		repeat (n) frame_done();
		`CHK("sink_drained", last, sink_output_n_o)
		$display("TB: fifo done");
		send(16'hFFFF);
		repeat (40) @(negedge clk_sys_i);
		rst_i = 1'b1;
		repeat (2) @(negedge clk_sys_i);
		rst_i = 1'b0;
		@(negedge clk_sys_i);
		`CHK("sink_midreset", 16'h0000, sink_output_n_o)
		`CHK("ready_midreset", 1'b1, word_ready_o)
		`CHK("loaded_midreset", 1'b0, loaded_o)
		send(16'hC003);
		frame_done();
		`CHK("sink_after_reset", 16'hC003, sink_output_n_o)
		$display("TB: reset done");
		print_verdict;
	end
endmodule
